// *** hdl/wws_pkg.sv ***
// Shared constants, types and window table for the windowed watchdog supervisor
package wws_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MR_MIN_NS     = 1000;
  localparam int unsigned MR_MIN_CYC    = (MR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned US_PER_MS     = 1000;

  localparam int DIV_W = 6;
  localparam int CNT_W = 27;

  typedef logic [DIV_W-1:0] wws_div_t;
  typedef logic [CNT_W-1:0] wws_cnt_t;

  localparam wws_div_t DIV_ZERO  = 6'h0;
  localparam wws_div_t DIV_ONE   = 6'h1;
  localparam wws_div_t TICK_LAST = DIV_W'(TICK_CYC - 1);
  localparam wws_div_t MR_LAST   = DIV_W'(MR_MIN_CYC - 1);

  localparam wws_cnt_t CNT_ZERO = 27'h0;
  localparam wws_cnt_t CNT_ONE  = 27'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // Durations, in ticks of one microsecond
  localparam int unsigned HOLD_MS  = 180;
  localparam int unsigned FAULT_MS = 1;
  localparam wws_cnt_t    HOLD_US  = CNT_W'(HOLD_MS * US_PER_MS);
  localparam wws_cnt_t    FAULT_US = CNT_W'(FAULT_MS * US_PER_MS);

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog modes
  typedef enum logic [1:0] {
    WD_RESET = 2'b00,
    WD_RUN   = 2'b01,
    WD_FAULT = 2'b10
  } wws_mode_t;

  ////////////////////////////////////////////////////////////////////////////////
  // Window options 0..7, each limit mid-range, in microseconds
  function automatic wws_cnt_t wws_fast_us(input int unsigned sel);
    case (sel)
      0:       return 27'h4e2;
      1,2,3,4: return 27'h30d4;
      5:       return 27'h4e20;
      6:       return 27'h84d0;
      default: return 27'h9a0d8;
    endcase
  endfunction

  function automatic wws_cnt_t wws_slow_us(input int unsigned sel);
    case (sel)
      0:       return 27'h30d4;
      1:       return 27'h1e848;
      2:       return 27'h5b8d8;
      3:       return 27'hbebc20;
      4:       return 27'h47868c0;
      5:       return 27'hd6d8;
      6:       return 27'h17318;
      default: return 27'h17a6b0;
    endcase
  endfunction

endpackage

// *** hdl/wws_base_if.sv ***
// Time base tick and filtered manual reset passed between supervisor modules
`timescale 1ns/100ps
`default_nettype none
interface wws_base_if;
  logic tick;
  logic mr_act;
  modport src (output tick, output mr_act);
  modport snk (input tick, input mr_act);
endinterface
`default_nettype wire

// *** hdl/wws_base.sv ***
// Microsecond time base and manual reset glitch filter
`timescale 1ns/100ps
`default_nettype none
module wws_base
  import wws_pkg::*;
(
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_b,
  // Manual reset pin
  input  wire logic   manual_reset_n,
  // To the supervisor core
  wws_base_if.src     base
);

  typedef struct packed {
    wws_div_t div;
    logic     tick;
    wws_div_t low_cnt;
    logic     act;
  } wws_base_state_t;

  wws_base_state_t st_q;
  wws_base_state_t st_d;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    if (st_q.div == TICK_LAST) begin
      st_d.div  = DIV_ZERO;
      st_d.tick = 1'b1;
    end else begin
      st_d.div  = st_q.div + DIV_ONE;
      st_d.tick = 1'b0;
    end
    // Low must stand the full minimum before it counts
    if (manual_reset_n) begin
      st_d.low_cnt = DIV_ZERO;
      st_d.act     = 1'b0;
    end else if (st_q.low_cnt == MR_LAST) begin
      st_d.act = 1'b1;
    end else begin
      st_d.low_cnt = st_q.low_cnt + DIV_ONE;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign base.tick   = st_q.tick;
  assign base.mr_act = st_q.act;

  AST_MR_GLITCH: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(st_q.act) |-> !$past(manual_reset_n, 1) && (st_q.low_cnt == MR_LAST))
    else $error("manual reset taken before its minimum low time");

endmodule
`default_nettype wire

// *** hdl/wws_top.sv ***
// Supply and activity supervisor with reset generator and windowed watchdog
`timescale 1ns/100ps
`default_nettype none
module wws_top
  import wws_pkg::*;
#(
  parameter int unsigned WINDOW_SEL  = 0,
  parameter wws_cnt_t    FAST_TICKS  = wws_fast_us(WINDOW_SEL),
  parameter wws_cnt_t    SLOW_TICKS  = wws_slow_us(WINDOW_SEL),
  parameter wws_cnt_t    HOLD_TICKS  = HOLD_US,
  parameter wws_cnt_t    FAULT_TICKS = FAULT_US
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Supervised conditions
  input  wire logic supply_low,
  input  wire logic manual_reset_n,
  // Processor kick
  input  wire logic watchdog_kick_in,
  // Reset output, push-pull
  output var  logic reset_out_n,
  // Fault pulse, open-drain: enable high while pulling low
  output var  logic watchdog_fault_pulse_n,
  output var  logic watchdog_fault_oe,
  // Fault kind, held during the pulse
  output var  logic fast_fault,
  output var  logic slow_fault
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic      reset_n;
    logic      fault_n;
    logic      fault_oe;
    logic      fast_flag;
    logic      slow_flag;
    logic      kick_prev;
    logic      first;
    wws_mode_t mode;
    wws_cnt_t  hold_cnt;
    wws_cnt_t  wd_cnt;
    wws_cnt_t  fault_cnt;
  } wws_state_t;

  localparam wws_state_t ST_RESET = '{
    reset_n:   1'b0,
    fault_n:   1'b1,
    fault_oe:  1'b0,
    fast_flag: 1'b0,
    slow_flag: 1'b0,
    kick_prev: 1'b1,
    first:     1'b1,
    mode:      WD_RESET,
    hold_cnt:  27'h0,
    wd_cnt:    27'h0,
    fault_cnt: 27'h0
  };

  wws_state_t st_q;
  wws_state_t st_d;

  wws_base_if base_i ();

  logic kick_edge;
  logic cause;

  ////////////////////////////////////////////////////////////////////////////////
  // Time base and manual reset filter

  wws_base u_base (
    .clock          (clock),
    .rst_b          (rst_b),
    .manual_reset_n (manual_reset_n),
    .base           (base_i)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic wws_state_t start_fault(input wws_state_t s, input logic fast);
    wws_state_t r;
    r           = s;
    r.mode      = WD_FAULT;
    r.fault_n   = 1'b0;
    r.fault_oe  = 1'b1;
    r.fast_flag = fast;
    r.slow_flag = ~fast;
    r.fault_cnt = CNT_ZERO;
    r.wd_cnt    = CNT_ZERO;
    return r;
  endfunction

  function automatic wws_state_t rearm(input wws_state_t s);
    wws_state_t r;
    r           = s;
    r.fault_n   = 1'b1;
    r.fault_oe  = 1'b0;
    r.fast_flag = 1'b0;
    r.slow_flag = 1'b0;
    r.wd_cnt    = CNT_ZERO;
    r.first     = 1'b1;
    return r;
  endfunction

  function automatic logic at_limit(input wws_cnt_t cnt, input wws_cnt_t limit);
    return cnt >= limit - CNT_ONE;
  endfunction

  assign kick_edge = st_q.kick_prev & ~watchdog_kick_in;
  assign cause     = supply_low | base_i.mr_act;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d           = st_q;
    st_d.kick_prev = watchdog_kick_in;

    // Reset generator
    if (cause) begin
      st_d.reset_n  = 1'b0;
      st_d.hold_cnt = CNT_ZERO;
    end else if (!st_q.reset_n && base_i.tick) begin
      if (at_limit(st_q.hold_cnt, HOLD_TICKS)) begin
        st_d.reset_n = 1'b1;
      end else begin
        st_d.hold_cnt = st_q.hold_cnt + CNT_ONE;
      end
    end

    // Watchdog
    unique case (st_q.mode)
      WD_RESET: begin
        st_d = rearm(st_d);
        if (st_q.reset_n) begin
          st_d.mode = WD_RUN;
        end
      end
      WD_RUN: begin
        if (kick_edge) begin
          if (!st_q.first && st_q.wd_cnt < FAST_TICKS) begin
            st_d = start_fault(st_d, 1'b1);
          end else begin
            st_d.wd_cnt = CNT_ZERO;
            st_d.first  = 1'b0;
          end
        end else if (base_i.tick) begin
          if (at_limit(st_q.wd_cnt, SLOW_TICKS)) begin
            st_d = start_fault(st_d, 1'b0);
          end else begin
            st_d.wd_cnt = st_q.wd_cnt + CNT_ONE;
          end
        end
      end
      WD_FAULT: begin
        // Kicks are not looked at here
        st_d.wd_cnt = CNT_ZERO;
        if (base_i.tick) begin
          if (at_limit(st_q.fault_cnt, FAULT_TICKS)) begin
            st_d      = rearm(st_d);
            st_d.mode = WD_RUN;
          end else begin
            st_d.fault_cnt = st_q.fault_cnt + CNT_ONE;
          end
        end
      end
      default: begin
        st_d      = rearm(st_d);
        st_d.mode = WD_RESET;
      end
    endcase

    // Reset active: timer cleared, fault pin released, kicks ignored
    if (!st_d.reset_n) begin
      st_d      = rearm(st_d);
      st_d.mode = WD_RESET;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    reset_out_n            = st_q.reset_n;
    watchdog_fault_pulse_n = st_q.fault_n;
    watchdog_fault_oe      = st_q.fault_oe;
    fast_fault             = st_q.fast_flag;
    slow_fault             = st_q.slow_flag;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_RESET_ON_CAUSE: assert property (@(posedge clock) disable iff (!rst_b)
    cause |=> !st_q.reset_n)
    else $error("reset output not low while a reset cause is present");

  AST_RESET_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(st_q.reset_n) |-> $past(st_q.hold_cnt) == HOLD_TICKS - CNT_ONE
      && !$past(cause))
    else $error("reset released before the hold period");

  AST_FAST_FAULT: assert property (@(posedge clock) disable iff (!rst_b)
    (st_q.mode == WD_RUN) && kick_edge && !st_q.first && (st_q.wd_cnt < FAST_TICKS)
      && st_q.reset_n && !cause
    |=> !watchdog_fault_pulse_n && fast_fault && watchdog_fault_oe)
    else $error("early kick did not raise a fast fault");

  AST_SLOW_FAULT: assert property (@(posedge clock) disable iff (!rst_b)
    (st_q.mode == WD_RUN) && !kick_edge && base_i.tick
      && (st_q.wd_cnt == SLOW_TICKS - CNT_ONE) && st_q.reset_n && !cause
    |=> !watchdog_fault_pulse_n && slow_fault)
    else $error("missing kick did not raise a slow fault");

  AST_PULSE_LEN: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(st_q.fault_n) && st_q.reset_n |-> $past(st_q.fault_cnt) == FAULT_TICKS - CNT_ONE)
    else $error("fault pulse ended at the wrong length");

  AST_FIRST_FREE: assert property (@(posedge clock) disable iff (!rst_b)
    (st_q.mode == WD_RUN) && st_q.first && kick_edge && st_q.reset_n && !cause
    |=> st_q.fault_n ##0 st_q.wd_cnt == CNT_ZERO ##0 !st_q.first)
    else $error("first kick after release raised a fault");

  AST_MR_CLEARS: assert property (@(posedge clock) disable iff (!rst_b)
    base_i.mr_act |=> !reset_out_n && watchdog_fault_pulse_n && !watchdog_fault_oe
      && (st_q.wd_cnt == CNT_ZERO))
    else $error("manual reset did not clear the watchdog");

  AST_FAULT_IGNORES: assert property (@(posedge clock) disable iff (!rst_b)
    (st_q.mode == WD_FAULT) && kick_edge |=> (st_q.wd_cnt == CNT_ZERO)
      && ($past(st_q.fault_cnt) <= st_q.fault_cnt || st_q.fault_n))
    else $error("kick acted while the fault pulse was active");

  AST_RESTART: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(st_q.fault_n) || $rose(st_q.reset_n)
    |-> (st_q.wd_cnt == CNT_ZERO) && st_q.first)
    else $error("timer not restarted on release");

  AST_FAULT_NEEDS_RUN: assert property (@(posedge clock) disable iff (!rst_b)
    !reset_out_n |-> watchdog_fault_pulse_n && !watchdog_fault_oe)
    else $error("fault pulse while reset is asserted");

  AST_HOLD_RESTART: assert property (@(posedge clock) disable iff (!rst_b)
    cause |=> (st_q.hold_cnt == CNT_ZERO))
    else $error("hold counter not restarted by a reset cause");

  AST_HOLD_BOUND: assert property (@(posedge clock) disable iff (!rst_b)
    !st_q.reset_n |-> (st_q.hold_cnt < HOLD_TICKS))
    else $error("hold counter ran past the hold period");

  AST_PULSE_MIN: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(st_q.fault_n) && !cause |=> !st_q.fault_n)
    else $error("fault pulse ended one clock after it began");

  AST_PIN_PAIR: assert property (@(posedge clock) disable iff (!rst_b)
    watchdog_fault_oe != watchdog_fault_pulse_n)
    else $error("fault enable and fault value disagree");

  AST_ONE_KIND: assert property (@(posedge clock) disable iff (!rst_b)
    !watchdog_fault_pulse_n |-> (fast_fault != slow_fault))
    else $error("fault pulse without exactly one fault kind");

  AST_FLAGS_END: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(st_q.fault_n) |-> !fast_fault && !slow_fault)
    else $error("fault kind still shown after the pulse");

  AST_MODE_NEEDS_RELEASE: assert property (@(posedge clock) disable iff (!rst_b)
    (st_q.mode != WD_RESET) |-> st_q.reset_n)
    else $error("watchdog active while reset is asserted");

  AST_TIMER_BOUND: assert property (@(posedge clock) disable iff (!rst_b)
    (st_q.mode == WD_RUN) |-> (st_q.wd_cnt < SLOW_TICKS))
    else $error("watchdog timer ran past the slow limit");

  AST_KICK_IN_RESET: assert property (@(posedge clock) disable iff (!rst_b)
    !st_q.reset_n && kick_edge |=> st_q.first && (st_q.wd_cnt == CNT_ZERO))
    else $error("kick acted while reset was asserted");

endmodule
`default_nettype wire

// *** testbench/wws_cpu_model.sv ***
// Processor model that kicks the watchdog with a fixed gap between falling edges
`timescale 1ns/100ps
`default_nettype none
module wws_cpu_model (
  // Clock
  input  wire logic        clock,
  // Control from the bench
  input  wire logic        kick_run,
  input  wire logic [15:0] kick_gap,
  // Kick line to the supervisor
  output var  logic        watchdog_kick_in
);
  int cnt;

  initial begin
    watchdog_kick_in = 1'b1;
    cnt              = 0;
  end

  // Gap must exceed 16 clocks so the low phase always completes
  always @(negedge clock) begin
    if (!kick_run) begin
      cnt              <= 0;
      watchdog_kick_in <= 1'b1;
    end else begin
      cnt <= (cnt + 1 >= int'(kick_gap)) ? 0 : cnt + 1;
      if (cnt + 1 == int'(kick_gap))
        watchdog_kick_in <= 1'b0;
      else if (cnt == 15)
        watchdog_kick_in <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the windowed watchdog supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench
  import wws_pkg::*;
;
  localparam int HOLD  = 20;
  localparam int FAULT = 5;
  localparam int FAST  = 10;
  localparam int SLOW  = 50;
  localparam int TK    = int'(TICK_CYC);
  localparam int HLO   = (HOLD - 1) * TK;
  localparam int HHI   = HOLD * TK + 3;

  logic        clock;
  logic        rst_b;
  logic        supply_low;
  logic        manual_reset_n;
  logic        kick_run;
  logic [15:0] kick_gap;
  logic        watchdog_kick_in;
  logic        reset_out_n;
  logic        watchdog_fault_pulse_n;
  logic        watchdog_fault_oe;
  logic        fast_fault;
  logic        slow_fault;
  wire  logic  fault_pin;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          c;
  int          h;

  // Open-drain fault pin with pull-up
  assign fault_pin = watchdog_fault_oe ? 1'b0 : 1'b1;

  wws_top #(
    .WINDOW_SEL  (0),
    .FAST_TICKS  (wws_cnt_t'(FAST)),
    .SLOW_TICKS  (wws_cnt_t'(SLOW)),
    .HOLD_TICKS  (wws_cnt_t'(HOLD)),
    .FAULT_TICKS (wws_cnt_t'(FAULT))
  ) u_dut (
    .clock                  (clock),
    .rst_b                  (rst_b),
    .supply_low             (supply_low),
    .manual_reset_n         (manual_reset_n),
    .watchdog_kick_in       (watchdog_kick_in),
    .reset_out_n            (reset_out_n),
    .watchdog_fault_pulse_n (watchdog_fault_pulse_n),
    .watchdog_fault_oe      (watchdog_fault_oe),
    .fast_fault             (fast_fault),
    .slow_fault             (slow_fault)
  );

  wws_cpu_model u_cpu (
    .clock            (clock),
    .kick_run         (kick_run),
    .kick_gap         (kick_gap),
    .watchdog_kick_in (watchdog_kick_in)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic in_rng(input int cyc, input int lo, input int hi);
    check((cyc >= lo && cyc <= hi) ? 32'(lo) : 32'(cyc), 32'(lo));
  endtask

  task automatic give_verdict;
    $display("compared=%0d errors=%0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Sel 0 watches the reset output, 1 the fault enable
  task automatic wait_for(input int sel, input logic val, input int limit, output int cyc);
    logic s;
    cyc = 0;
    forever begin
      @(negedge clock);
      cyc++;
      s = (sel == 0) ? reset_out_n : watchdog_fault_oe;
      if (s === val)
        return;
      if (cyc >= limit) begin
        n_errors++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, val);
        give_verdict();
      end
    end
  endtask

  task automatic quiet(input int n, output int hits);
    hits = 0;
    repeat (n) begin
      @(negedge clock);
      if (watchdog_fault_oe !== 1'b0)
        hits++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_supply;
    supply_low = 1'b1;
    wait_for(0, 1'b0, 4, c);
    in_rng(c, 1, 3);
    repeat (4) @(negedge clock);
    check(fault_pin, 1'b1);
    supply_low = 1'b0;
    wait_for(0, 1'b1, HHI + 2, c);
    in_rng(c, HLO, HHI);
  endtask

  task automatic t_manual;
    manual_reset_n = 1'b0;
    h = 0;
    repeat (30) @(negedge clock);
    manual_reset_n = 1'b1;
    repeat (10) begin
      @(negedge clock);
      if (reset_out_n !== 1'b1)
        h++;
    end
    check(h, 0);
    manual_reset_n = 1'b0;
    wait_for(0, 1'b0, 50, c);
    in_rng(c, 40, 44);
    repeat (20) @(negedge clock);
    manual_reset_n = 1'b1;
    wait_for(0, 1'b1, HHI + 2, c);
    in_rng(c, HLO, HHI);
  endtask

  task automatic t_good;
    t_supply();
    kick_gap <= 16'h0320;
    kick_run <= 1'b1;
    quiet(4200, h);
    check(h, 0);
    kick_run <= 1'b0;
  endtask

  task automatic t_fast;
    t_supply();
    kick_gap <= 16'h0078;
    kick_run <= 1'b1;
    wait_for(1, 1'b1, 300, c);
    in_rng(c, 238, 244);
    check({fast_fault, slow_fault, fault_pin}, 3'h4);
    check(watchdog_fault_pulse_n, fault_pin);
    wait_for(1, 1'b0, FAULT * TK + 5, c);
    in_rng(c, (FAULT - 1) * TK, FAULT * TK + 2);
    check(fast_fault, 1'b0);
    quiet(100, h);
    check(h, 0);
    kick_run <= 1'b0;
  endtask

  task automatic t_slow;
    t_supply();
    wait_for(1, 1'b1, SLOW * TK + 10, c);
    in_rng(c, (SLOW - 1) * TK, SLOW * TK + 3);
    check({fast_fault, slow_fault}, 2'h1);
    wait_for(1, 1'b0, FAULT * TK + 5, c);
    in_rng(c, (FAULT - 1) * TK, FAULT * TK + 2);
    wait_for(1, 1'b1, SLOW * TK + 10, c);
    in_rng(c, (SLOW - 1) * TK, SLOW * TK + 3);
    manual_reset_n = 1'b0;
    wait_for(1, 1'b0, 50, c);
    in_rng(c, 40, 44);
    check({reset_out_n, fault_pin}, 2'h1);
    quiet(2200, h);
    check(h, 0);
    manual_reset_n = 1'b1;
    wait_for(0, 1'b1, HHI + 2, c);
    in_rng(c, HLO, HHI);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b          = 1'b0;
    supply_low     = 1'b0;
    manual_reset_n = 1'b1;
    kick_run       = 1'b0;
    kick_gap       = 16'h0320;
    repeat (5) @(negedge clock);
    check({reset_out_n, fault_pin}, 2'h1);
    rst_b = 1'b1;
    wait_for(0, 1'b1, HHI + 2, c);
    in_rng(c, HLO, HHI);
    t_supply();
    t_manual();
    t_good();
    t_fast();
    t_slow();
    give_verdict();
  end
endmodule
`default_nettype wire
